// File: rtl/pulse_compensator.sv
// Crystal pulse insertion and removal spread evenly by a fractional accumulator
`include "rtc_map.svh"
module pulse_compensator
	import rtc_pkg::*;
#(
	parameter int ACC_W = 20
) (
	// Clock and control
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// Crystal pulse in, signed correction in 2 ppm steps
	input wire logic xtal_pulse,
	input wire comp_t comp,
	// Corrected pulse out
	output logic out_pulse
);
	localparam logic [ACC_W-1:0] WRAP = ACC_W'(`PPM_FULL / `PPM_PER_STEP);
	logic [ACC_W-1:0] acc;
	logic [ACC_W-1:0] next_acc;
	logic [7:0] mag;
	logic owe_extra;
	logic adjust;

	always_comb begin
		mag = comp[7] ? 8'(-comp) : 8'(comp);
		next_acc = acc + ACC_W'(mag);
		adjust = next_acc >= WRAP;
		if (adjust) begin
			next_acc = next_acc - WRAP;
		end
	end

	// One step every WRAP/mag pulses keeps drift below one step [R25]
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			acc <= '0;
			owe_extra <= 1'b0;
			out_pulse <= 1'b0;
		end else if (ce) begin
			out_pulse <= 1'b0;
			owe_extra <= 1'b0;
			if (xtal_pulse) begin
				acc <= next_acc;
				// Negative correction speeds the clock: add a pulse [R12]
				out_pulse <= !(adjust && !comp[7]);
				owe_extra <= adjust && comp[7];
			end else if (owe_extra) begin
				out_pulse <= 1'b1;
			end
		end
	end
endmodule : pulse_compensator

// File: rtl/rtc_event_comp.sv
// RTC events, interval timer, alarm, crystal compensation and calibration output
`include "rtc_map.svh"
// Overview of operation
// R1: Events set flag; enabled pending interrupt reaches core
// R2: Vectoring leaves flag; software clears it
// R3: Pending stays while flag set, even disabled
// R4: Keep waking while RTC interrupt unserviced
// R5: Enabled interval timer counts selected timebase
// R6: Count equal to length raises interval event
// R7: Repeat clears counter; single-shot holds it
// R8: Software changes timebase in documented order
// R9: Timebase write applies after one 128 Hz tick
// R10: All enabled alarm fields matching sets alarm
// R11: Alarm flag is bit 6 of alarm config
// R12: Correct crystal by inserting or removing pulses
// R13: Nominal plus temperature term, limited to 248 ppm
// R14: Calibration output on pins, when enabled
// R15: Normal modes give 1 Hz and 512 Hz
// R16: Fast modes give 500 Hz and 16.384 kHz
// R17: Fast modes clock RTC 125 times faster
// R18: Temperature term is gain times offset squared
// R19: Auto compensation off at reset; then read-only
// R20: Recompute term on each new temperature reading
// R21: Software schedules background temperature readings
// R22: Compensation readings leave result registers untouched
// R23: Each pin-select bit routes output when enabled
// R24: Signed compensation sum saturates, never wraps
// R25: Corrections spread evenly, drift under one step
module rtc_event_comp
	import rtc_pkg::*;
(
	// Clock, reset, clock enable
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// Special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output sfr_byte_t sfr_rdata,
	// Time base pulses from the crystal domain
	input wire logic xtal_pulse,
	input wire logic tick_128hz,
	input wire logic [3:0] interval_tick,
	// Live timekeeping fields
	input wire logic [7:0] time_second,
	input wire logic [7:0] time_minute,
	input wire logic [7:0] time_hour,
	input wire logic [7:0] time_weekday,
	input wire logic [7:0] time_monthday,
	// Alarm settings
	input wire logic [7:0] alarm_second,
	input wire logic [7:0] alarm_minute,
	input wire logic [7:0] alarm_hour,
	input wire logic [7:0] alarm_weekday,
	input wire logic [7:0] alarm_monthday,
	// Background temperature measurement
	input wire logic [7:0] temperature_reading,
	input wire logic temp_reading_done,
	// Power mode inputs: full, battery and sleep
	input wire logic full_power_mode,
	input wire logic battery_power_mode,
	input wire logic sleep_power_mode,
	// Outputs
	output logic rtc_irq,
	output logic wake_request,
	output logic rtc_clk_pulse,
	output logic fast_cal_mode,
	output logic [3:0] cal_pin
);
	sfr_byte_t cal_config;
	sfr_byte_t interval_length;
	sfr_byte_t gain_low;
	sfr_byte_t gain_high;
	sfr_byte_t crystal_temp_offset;
	sfr_byte_t irq_enable_priority_two;
	comp_t rtc_nominal_comp;
	comp_t rtc_temperature_comp;
	logic interval_enable;
	logic single_shot_interval;
	logic [1:0] timebase_req;
	logic interval_enable_active;
	logic [1:0] timebase_active;
	logic interval_event_flag;
	logic [4:0] alarm_enable;
	logic alarm_event_flag;
	logic [7:0] interval_count;
	logic interval_held;
	logic interval_event;
	logic alarm_match;
	logic alarm_match_q;
	logic alarm_event;
	logic pending;
	comp_t comp_sum;
	logic corrected_pulse;
	logic [14:0] cal_div;
	logic [15:0] fast_acc;
	logic fast_wave;
	logic cal_wave;
	logic [14:0] crystal_temp_gain;
	logic signed [8:0] temp_delta;
	logic [16:0] delta_sq;
	logic [31:0] temp_product;
	logic [16:0] temp_term;

	function automatic logic wr_hit(input logic [7:0] addr);
		wr_hit = sfr_wr && (sfr_addr == addr);
	endfunction : wr_hit

	// Plain configuration bytes
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cal_config <= `BYTE_RESET;
			interval_length <= `INTERVAL_RESET;
			gain_low <= `BYTE_RESET;
			gain_high <= `BYTE_RESET;
			crystal_temp_offset <= `BYTE_RESET;
			irq_enable_priority_two <= `BYTE_RESET;
			rtc_nominal_comp <= comp_t'(`BYTE_RESET);
		end else if (ce) begin
			if (wr_hit(`ADDR_CAL_CONFIG)) cal_config <= sfr_wdata;
			if (wr_hit(`ADDR_INTERVAL_LENGTH)) interval_length <= sfr_wdata;
			if (wr_hit(`ADDR_GAIN_LOW)) gain_low <= sfr_wdata;
			if (wr_hit(`ADDR_GAIN_HIGH)) gain_high <= sfr_wdata; // [R19]
			if (wr_hit(`ADDR_TEMP_OFFSET)) crystal_temp_offset <= sfr_wdata;
			if (wr_hit(`ADDR_IRQ_ENABLE_PRIO)) irq_enable_priority_two <= sfr_wdata;
			if (wr_hit(`ADDR_NOMINAL_COMP)) rtc_nominal_comp <= comp_t'(sfr_wdata);
		end
	end

	// Interval control; enable and timebase reach the counter on a 128 Hz tick
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			interval_enable <= 1'b0;
			single_shot_interval <= 1'b0;
			timebase_req <= 2'b00;
			interval_enable_active <= 1'b0;
			timebase_active <= 2'b00;
		end else if (ce) begin
			if (wr_hit(`ADDR_INTERVAL_CONFIG)) begin
				interval_enable <= sfr_wdata[`IC_ENABLE];
				single_shot_interval <= sfr_wdata[`IC_SINGLE_SHOT];
				timebase_req <= sfr_wdata[`IC_TB_HI:`IC_TB_LO];
			end
			if (tick_128hz) begin
				interval_enable_active <= interval_enable;
				timebase_active <= timebase_req; // [R9]
			end
		end
	end

	// Interval counter
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			interval_count <= 8'h00;
			interval_held <= 1'b0;
			interval_event <= 1'b0;
		end else if (ce) begin
			interval_event <= 1'b0;
			if (!interval_enable_active) begin
				interval_count <= 8'h00;
				interval_held <= 1'b0;
			end else if (interval_held) begin
				interval_count <= 8'h00; // [R7]
			end else if (interval_tick[timebase_active]) begin // [R5]
				if (interval_count + 8'h01 == interval_length) begin
					interval_event <= 1'b1; // [R6]
					interval_count <= 8'h00; // [R7]
					interval_held <= single_shot_interval; // [R7]
				end else begin
					interval_count <= interval_count + 8'h01; // [R6]
				end
			end
		end
	end

	// Alarm compare; only the rising match counts so a cleared flag stays clear
	always_comb begin
		alarm_match = (|alarm_enable) &&
			(!alarm_enable[0] || time_second == alarm_second) &&
			(!alarm_enable[1] || time_minute == alarm_minute) &&
			(!alarm_enable[2] || time_hour == alarm_hour) &&
			(!alarm_enable[3] || time_weekday == alarm_weekday) &&
			(!alarm_enable[4] || time_monthday == alarm_monthday); // [R10]
		alarm_event = alarm_match && !alarm_match_q;
	end

	// Alarm config and both event flags; a set in the clear cycle wins
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			alarm_enable <= 5'h00;
			alarm_match_q <= 1'b0;
			alarm_event_flag <= 1'b0;
			interval_event_flag <= 1'b0;
		end else if (ce) begin
			alarm_match_q <= alarm_match;
			if (wr_hit(`ADDR_ALARM_CONFIG)) begin
				alarm_enable <= sfr_wdata[`AC_EN_HI:0];
				if (!sfr_wdata[`AC_FLAG]) alarm_event_flag <= 1'b0; // [R2]
			end
			if (wr_hit(`ADDR_INTERVAL_CONFIG) && !sfr_wdata[`IC_FLAG]) begin
				interval_event_flag <= 1'b0; // [R2]
			end
			if (alarm_event) alarm_event_flag <= 1'b1; // [R1] [R10]
			if (interval_event) interval_event_flag <= 1'b1; // [R1] [R6]
		end
	end

	assign pending = alarm_event_flag || interval_event_flag; // [R3]

	// Interrupt and wake outputs follow the flags, not the vector fetch
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rtc_irq <= 1'b0;
			wake_request <= 1'b0;
		end else if (ce) begin
			rtc_irq <= pending && irq_enable_priority_two[`IE_RTC_ENABLE]; // [R1] [R3]
			wake_request <= pending && sleep_power_mode; // [R4]
		end
	end

	// Temperature term from gain and squared offset
	always_comb begin
		crystal_temp_gain = {gain_high[6:0], gain_low}; // [R18]
		temp_delta = $signed({1'b0, temperature_reading}) - $signed({1'b0, crystal_temp_offset});
		delta_sq = 17'(temp_delta * temp_delta);
		temp_product = 32'(crystal_temp_gain) * 32'(delta_sq);
		temp_term = 17'(temp_product >> `GAIN_SHIFT); // [R18]
	end

	// Compensation reads use a private path; no result register is touched here [R22]
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rtc_temperature_comp <= comp_t'(`BYTE_RESET);
		end else if (ce) begin
			if (gain_high[`GAIN_AUTO]) begin
				if (temp_reading_done) begin // [R20]
					rtc_temperature_comp <= (temp_term > 17'(`TEMP_COMP_MAX)) ?
						comp_t'(`TEMP_COMP_MAX) : comp_t'(temp_term[7:0]);
				end
			end else if (wr_hit(`ADDR_TEMP_COMP)) begin
				rtc_temperature_comp <= comp_t'(sfr_wdata); // [R19]
			end
		end
	end

	// Signed sum clipped to the allowed range [R24]
	always_comb begin
		logic signed [8:0] raw;
		raw = 9'(rtc_nominal_comp) + 9'(rtc_temperature_comp);
		if (raw > 9'sd`COMP_LIMIT) begin
			comp_sum = comp_t'(`COMP_LIMIT); // [R13]
		end else if (raw < -9'sd`COMP_LIMIT) begin
			comp_sum = comp_t'(-`COMP_LIMIT); // [R13]
		end else begin
			comp_sum = comp_t'(raw[7:0]);
		end
	end

	pulse_compensator u_comp (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.xtal_pulse(xtal_pulse),
		.comp(comp_sum),
		.out_pulse(corrected_pulse)
	); // [R12]

	// Calibration dividers driven by the corrected clock
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cal_div <= 15'h0000;
			fast_acc <= 16'h0000;
			fast_wave <= 1'b0;
		end else if (ce && corrected_pulse) begin
			cal_div <= cal_div + 15'h0001;
			// Fractional step gives a 500 Hz average at some jitter cost
			if (fast_acc + 16'(`FAST_HALF_STEP) >= 16'(`XTAL_HZ)) begin
				fast_acc <= fast_acc + 16'(`FAST_HALF_STEP) - 16'(`XTAL_HZ);
				fast_wave <= !fast_wave;
			end else begin
				fast_acc <= fast_acc + 16'(`FAST_HALF_STEP);
			end
		end
	end

	always_comb begin
		case (cal_freq_t'(cal_config[`CAL_FSEL_HI:`CAL_FSEL_LO]))
			cal_1hz: cal_wave = cal_div[`DIV_1HZ_BIT]; // [R15]
			cal_512hz: cal_wave = cal_div[`DIV_512HZ_BIT]; // [R15]
			cal_500hz: cal_wave = fast_wave; // [R16]
			cal_16khz: cal_wave = cal_div[0]; // [R16]
			default: cal_wave = 1'b0;
		endcase
	end

	// Pin routing, fast mode flag and the corrected clock pulse
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cal_pin <= 4'h0;
			fast_cal_mode <= 1'b0;
			rtc_clk_pulse <= 1'b0;
		end else if (ce) begin
			for (int i = 0; i <= `CAL_PINS_HI; i++) begin
				cal_pin[i] <= cal_config[`CAL_ENABLE] && cal_config[i] && cal_wave; // [R14] [R23]
			end
			// Fast clocking only offered outside sleep [R16] [R17]
			fast_cal_mode <= cal_config[`CAL_FSEL_HI] && (full_power_mode || battery_power_mode);
			rtc_clk_pulse <= corrected_pulse;
		end
	end

	// Registered read; unmapped addresses read zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sfr_rdata <= `BYTE_RESET;
		end else if (ce) begin
			case (sfr_addr)
				`ADDR_CAL_CONFIG: sfr_rdata <= cal_config;
				`ADDR_INTERVAL_LENGTH: sfr_rdata <= interval_length;
				`ADDR_GAIN_LOW: sfr_rdata <= gain_low;
				`ADDR_GAIN_HIGH: sfr_rdata <= gain_high;
				`ADDR_TEMP_OFFSET: sfr_rdata <= crystal_temp_offset;
				`ADDR_IRQ_ENABLE_PRIO: sfr_rdata <= irq_enable_priority_two;
				`ADDR_NOMINAL_COMP: sfr_rdata <= rtc_nominal_comp;
				`ADDR_TEMP_COMP: sfr_rdata <= rtc_temperature_comp;
				// Enable reads back the applied state so software can poll it [R8]
				`ADDR_INTERVAL_CONFIG: sfr_rdata <= {3'b000, timebase_req,
					interval_event_flag, single_shot_interval, interval_enable_active};
				`ADDR_ALARM_CONFIG: sfr_rdata <= {1'b0, alarm_event_flag, 1'b0,
					alarm_enable}; // [R11]
				default: sfr_rdata <= `BYTE_RESET;
			endcase
		end
	end
endmodule : rtc_event_comp

// File: rtl/rtc_map.svh
// Register offsets, field positions, reset values and timing constants for the RTC support block
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
`define ADDR_CAL_CONFIG 8'h0f
`define ADDR_INTERVAL_LENGTH 8'h10
`define ADDR_GAIN_LOW 8'h11
`define ADDR_GAIN_HIGH 8'h12
`define ADDR_TEMP_OFFSET 8'h13
`define ADDR_INTERVAL_CONFIG 8'ha1
`define ADDR_ALARM_CONFIG 8'ha2
`define ADDR_IRQ_ENABLE_PRIO 8'ha9
`define ADDR_NOMINAL_COMP 8'hf6
`define ADDR_TEMP_COMP 8'hf7
`define BYTE_RESET 8'h00
`define INTERVAL_RESET 8'hff
`define IC_ENABLE 0
`define IC_SINGLE_SHOT 1
`define IC_FLAG 2
`define IC_TB_LO 3
`define IC_TB_HI 4
`define AC_FLAG 6
`define AC_EN_HI 4
`define IE_RTC_ENABLE 2
`define CAL_ENABLE 6
`define CAL_FSEL_LO 4
`define CAL_FSEL_HI 5
`define CAL_PINS_HI 3
`define GAIN_AUTO 7
`define GAIN_SHIFT 15
`define COMP_LIMIT 124
`define TEMP_COMP_MAX 127
`define PPM_PER_STEP 2
`define PPM_FULL 1000000
`define XTAL_HZ 32768
`define FAST_HALF_STEP 1000
`define DIV_1HZ_BIT 14
`define DIV_512HZ_BIT 5
`endif

// File: rtl/rtc_pkg.sv
// Types shared by the RTC support block
package rtc_pkg;
	typedef logic [7:0] sfr_byte_t;
	typedef logic signed [7:0] comp_t;
	typedef enum logic [1:0] {
		cal_1hz = 2'b00,
		cal_512hz = 2'b01,
		cal_500hz = 2'b10,
		cal_16khz = 2'b11
	} cal_freq_t;
endpackage : rtc_pkg

// File: verif/rtc_event_comp_checker.sv
// Port-level assertions for the RTC support block
`include "rtc_map.svh"
module rtc_event_comp_checker
	import rtc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	// Inputs
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic xtal_pulse,
	input wire logic full_power_mode,
	input wire logic battery_power_mode,
	input wire logic sleep_power_mode,
	// Outputs
	input wire logic rtc_irq,
	input wire logic wake_request,
	input wire logic rtc_clk_pulse,
	input wire logic fast_cal_mode,
	input wire logic [3:0] cal_pin
);
	logic ie;
	logic [7:0] cal;
	logic wr_flag;
	// Mirror of written registers, so the rules can be judged from the ports alone
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ie <= 1'b0;
			cal <= 8'h00;
		end else if (ce && sfr_wr) begin
			if (sfr_addr == `ADDR_IRQ_ENABLE_PRIO)
				ie <= sfr_wdata[`IE_RTC_ENABLE];
			if (sfr_addr == `ADDR_CAL_CONFIG)
				cal <= sfr_wdata;
		end
	end
	// Any write that may clear a flag or the enable
	assign wr_flag = sfr_wr && (sfr_addr == `ADDR_INTERVAL_CONFIG
		|| sfr_addr == `ADDR_ALARM_CONFIG || sfr_addr == `ADDR_IRQ_ENABLE_PRIO);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_irq_en; rtc_irq |-> $past(ie); endproperty
	a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
	property p_irq_off;
		sfr_wr && sfr_addr == `ADDR_IRQ_ENABLE_PRIO && !sfr_wdata[`IE_RTC_ENABLE] |=> ##1 !rtc_irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq after disable");
	property p_hold; rtc_irq && !$past(wr_flag) && !$past(wr_flag, 2) |=> rtc_irq; endproperty
	a_hold: assert property (p_hold) else $error("pending dropped");
	property p_wake_src; wake_request |-> $past(sleep_power_mode); endproperty
	a_wake_src: assert property (p_wake_src) else $error("wake outside sleep");
	property p_wake_hold;
		wake_request && sleep_power_mode && !$past(wr_flag) && !$past(wr_flag, 2) |=> wake_request;
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake dropped");
	property p_fast; fast_cal_mode == $past(cal[5] && (full_power_mode || battery_power_mode)); endproperty
	a_fast: assert property (p_fast) else $error("fast mode wrong");
	property p_gate; (cal_pin & ~$past(cal[6] ? cal[3:0] : 4'h0)) == 4'h0; endproperty
	a_gate: assert property (p_gate) else $error("cal pin not selected");
	// Plain pulses trail the crystal by two cycles, added pulses by three
	property p_src; rtc_clk_pulse |-> $past(xtal_pulse, 2) || $past(xtal_pulse, 3); endproperty
	a_src: assert property (p_src) else $error("pulse without crystal");
	c_irq: cover property (rtc_irq);
	c_wake: cover property (wake_request);
	c_fast: cover property (fast_cal_mode);
	c_cal: cover property ($rose(cal_pin[0]));
endmodule : rtc_event_comp_checker

// File: verif/rtc_event_comp_tb.sv
// Self-checking bench for the RTC support block
`include "rtc_map.svh"
module rtc_event_comp_tb
	import rtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, tick_128hz = 1'b0, xtal_pulse = 1'b0;
	logic temp_reading_done = 1'b0, full_power_mode = 1'b0, battery_power_mode = 1'b0;
	logic sleep_power_mode = 1'b0, ce = 1'b1;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, temperature_reading = 8'h00;
	logic [3:0] interval_tick = 4'h0;
	logic [3:0] sel;
	logic [7:0] tm [5] = '{default: 8'h01};
	logic [7:0] al [5] = '{default: 8'h00};
	logic [7:0] amap [11] = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'ha1, 8'ha2, 8'ha9, 8'hf6,
		8'hf7, 8'h55};
	sfr_byte_t sfr_rdata, rd;
	logic rtc_irq, wake_request, rtc_clk_pulse, fast_cal_mode;
	logic [3:0] cal_pin;
	int n_fail = 0, checked = 0, seed = 72, cycles = 0;
	int n_in = 0, n_out = 0, n_goal = 0, ph = 0, gap = 2;
	int i, j, v, n0;
	rtc_event_comp DUT (
		.ref_clk, .rst, .ce, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .xtal_pulse,
		.tick_128hz, .interval_tick, .time_second(tm[0]), .time_minute(tm[1]), .time_hour(tm[2]),
		.time_weekday(tm[3]), .time_monthday(tm[4]), .alarm_second(al[0]), .alarm_minute(al[1]),
		.alarm_hour(al[2]), .alarm_weekday(al[3]), .alarm_monthday(al[4]), .temperature_reading,
		.temp_reading_done, .full_power_mode, .battery_power_mode, .sleep_power_mode, .rtc_irq,
		.wake_request, .rtc_clk_pulse, .fast_cal_mode, .cal_pin
	);
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	// Cut a hang short; the whole run needs about 60000 cycles
	always @(posedge ref_clk) begin
		cycles++;
		n_out += rtc_clk_pulse;
		if (cycles == 90000) begin
			n_fail++;
			results;
		end
	end
	// Crystal pulses, one every gap cycles, until n_goal are sent
	always @(negedge ref_clk) begin
		xtal_pulse <= 1'b0;
		ph <= (ph + 1) % gap;
		if (n_in < n_goal && ph == 0) begin
			xtal_pulse <= 1'b1;
			n_in <= n_in + 1;
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task results;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge ref_clk);
		sfr_wr = 1'b0;
	endtask : wr
	task rd_reg(input logic [7:0] a);
		@(negedge ref_clk);
		sfr_addr = a;
		@(negedge ref_clk);
		rd = sfr_rdata;
	endtask : rd_reg
	task pulse(input logic [3:0] it, input logic t);
		@(negedge ref_clk);
		interval_tick = it;
		tick_128hz = t;
		@(negedge ref_clk);
		interval_tick = 4'h0;
		tick_128hz = 1'b0;
	endtask : pulse
	task do_reset;
		@(negedge ref_clk);
		rst = 1'b1;
		n_goal = n_in;
		repeat (12) @(negedge ref_clk);
		rst = 1'b0;
	endtask : do_reset
	task wait_change;
		logic s;
		s = cal_pin[0];
		while (cal_pin[0] === s) @(negedge ref_clk);
	endtask : wait_change
	function automatic logic [7:0] exp_temp(input int g, input int d);
		int p;
		p = (g * d * d) >>> 15;
		return p > 127 ? 8'h7f : p[7:0];
	endfunction : exp_temp
	initial begin
		do_reset;
		for (i = 0; i < 11; i++) begin
			rd_reg(amap[i]);
			check(rd, i == 1 ? 8'hff : 8'h00);
		end
		// A write while the clock enable is low must be lost
		ce = 1'b0;
		wr(`ADDR_NOMINAL_COMP, 8'h5a);
		ce = 1'b1;
		rd_reg(`ADDR_NOMINAL_COMP);
		check(rd, 8'h00);
		// Every timebase, repeating and single shot
		for (i = 0; i < 8; i++) begin
			do_reset;
			v = i[1:0] * 8 + i[2] * 2 + 1;
			sel = 4'h1 << i[1:0];
			wr(`ADDR_IRQ_ENABLE_PRIO, 8'h04);
			wr(`ADDR_INTERVAL_LENGTH, 8'h03);
			wr(`ADDR_INTERVAL_CONFIG, v[7:0]);
			repeat (3) pulse(sel, 1'b0);
			rd_reg(`ADDR_INTERVAL_CONFIG);
			check({rd[2], rd[0]}, 2'b00);
			pulse(4'h0, 1'b1);
			repeat (5) pulse(~sel, 1'b0);
			repeat (2) pulse(sel, 1'b0);
			rd_reg(`ADDR_INTERVAL_CONFIG);
			check(rd[4:0], v[4:0]);
			pulse(sel, 1'b0);
			repeat (3) @(negedge ref_clk);
			rd_reg(`ADDR_INTERVAL_CONFIG);
			check(rd[4:0], v[4:0] | 5'h04);
			check(rtc_irq, 1'b1);
			wr(`ADDR_INTERVAL_CONFIG, v[7:0]);
			repeat (3) @(negedge ref_clk);
			check(rtc_irq, 1'b0);
			repeat (3) pulse(sel, 1'b0);
			repeat (3) @(negedge ref_clk);
			rd_reg(`ADDR_INTERVAL_CONFIG);
			check(rd[2], !i[2]);
			// Timebase change in the safe order: length, disable, poll, then timebase
			wr(`ADDR_INTERVAL_LENGTH, 8'h02);
			pulse(4'h0, 1'b1);
			wr(`ADDR_INTERVAL_CONFIG, 8'h00);
			rd_reg(`ADDR_INTERVAL_CONFIG);
			check(rd[0], 1'b1);
			pulse(4'h0, 1'b1);
			rd_reg(`ADDR_INTERVAL_CONFIG);
			check(rd[0], 1'b0);
			wr(`ADDR_INTERVAL_CONFIG, 8'h1d);
			pulse(4'h0, 1'b1);
			repeat (2) pulse(4'h8, 1'b0);
			repeat (3) @(negedge ref_clk);
			rd_reg(`ADDR_INTERVAL_CONFIG);
			check(rd[4:0], 5'h1d);
		end
		// Alarm with random enables, field zero always enabled
		for (i = 0; i < 4; i++) begin
			do_reset;
			v = ($random(seed) & 32'h1f) | 1;
			for (j = 0; j < 5; j++) begin
				al[j] = 8'($random(seed));
				tm[j] = al[j] ^ 8'h01;
			end
			sleep_power_mode = 1'b1;
			wr(`ADDR_ALARM_CONFIG, v[7:0]);
			for (j = 1; j < 5; j++)
				tm[j] = al[j];
			repeat (3) @(negedge ref_clk);
			rd_reg(`ADDR_ALARM_CONFIG);
			check(rd[6], 1'b0);
			tm[0] = al[0];
			repeat (3) @(negedge ref_clk);
			rd_reg(`ADDR_ALARM_CONFIG);
			check(rd & 8'h5f, v | 8'h40);
			check(rtc_irq, 1'b0);
			check(wake_request, 1'b1);
			wr(`ADDR_IRQ_ENABLE_PRIO, 8'h04);
			repeat (2) @(negedge ref_clk);
			check(rtc_irq, 1'b1);
			sleep_power_mode = 1'b0;
			wr(`ADDR_ALARM_CONFIG, v[7:0]);
			repeat (3) @(negedge ref_clk);
			check({rtc_irq, wake_request}, 2'b00);
		end
		// Automatic temperature term under write protection, then manual write
		for (i = 0; i < 4; i++) begin
			do_reset;
			v = $random(seed) & 32'h7fff;
			j = $random(seed) & 32'h7f;
			n0 = j + ($random(seed) & 32'h3f);
			wr(`ADDR_GAIN_LOW, v[7:0]);
			wr(`ADDR_GAIN_HIGH, {1'b1, v[14:8]});
			wr(`ADDR_TEMP_OFFSET, j[7:0]);
			temperature_reading = n0[7:0];
			@(negedge ref_clk);
			temp_reading_done = 1'b1;
			@(negedge ref_clk);
			temp_reading_done = 1'b0;
			repeat (3) @(negedge ref_clk);
			wr(`ADDR_TEMP_COMP, 8'h55);
			rd_reg(`ADDR_TEMP_COMP);
			check(rd, exp_temp(v, n0 - j));
			wr(`ADDR_GAIN_HIGH, {1'b0, v[14:8]});
			wr(`ADDR_TEMP_COMP, 8'h55);
			rd_reg(`ADDR_TEMP_COMP);
			check(rd, 8'h55);
		end
		// Sums past the limit: wrapping would give the opposite sign or none
		gap = 3;
		for (i = 0; i < 2; i++) begin
			do_reset;
			wr(`ADDR_NOMINAL_COMP, i ? 8'h80 : 8'h7f);
			wr(`ADDR_TEMP_COMP, i ? 8'h80 : 8'h7f);
			n0 = n_out;
			n_goal = n_in + 4096;
			while (n_in < n_goal) @(negedge ref_clk);
			repeat (8) @(negedge ref_clk);
			check(n_out - n0, i ? 4097 : 4095);
		end
		gap = 2;
		do_reset;
		wr(`ADDR_CAL_CONFIG, 8'h4f);
		n0 = n_out;
		n_goal = n_in + 20000;
		while (cal_pin[0] !== 1'b1) @(negedge ref_clk);
		check(n_out - n0, 16384);
		for (i = 1; i < 4; i++) begin
			do_reset;
			full_power_mode = 1'($random(seed));
			battery_power_mode = 1'($random(seed));
			v = (($random(seed) & 7) << 1) | 1;
			wr(`ADDR_CAL_CONFIG, 8'(8'h40 | i << 4 | v));
			repeat (2) @(negedge ref_clk);
			check(fast_cal_mode, i[1] & (full_power_mode | battery_power_mode));
			n_goal = n_in + 400;
			wait_change;
			check(cal_pin, v[3:0]);
			n0 = n_out;
			wait_change;
			j = n_out - n0;
			check(i == 2 ? (j >= 32 && j <= 33) : j, i == 1 ? 32 : 1);
			check(cal_pin, cal_pin[0] ? v[3:0] : 4'h0);
		end
		results;
	end
endmodule : rtc_event_comp_tb
bind rtc_event_comp rtc_event_comp_checker chk (.ref_clk, .rst, .ce, .sfr_addr, .sfr_wr,
	.sfr_wdata, .xtal_pulse, .full_power_mode, .battery_power_mode, .sleep_power_mode,
	.rtc_irq, .wake_request, .rtc_clk_pulse, .fast_cal_mode, .cal_pin);
